/* inc/sensor_exec_regs.vh */
// Purpose: constants for the execution and status block
// Assumes: 100 MHz i_ref_clk, registers reached by a plain register port
// Notes: offsets are register indices on the device register port
`ifndef SENSOR_EXEC_REGS_VH
`define SENSOR_EXEC_REGS_VH
`define REG_DATA_FLAGS 15'h0001
`define REG_LEVEL_FLAGS0 15'h0002
`define REG_LEVEL_FLAGS1 15'h0003
`define REG_CEIL_CH1 15'h0004
`define REG_CEIL_CH2 15'h0005
`define REG_QUEUE_FLAG 15'h0006
`define REG_RUN_CTRL 15'h0010
`define REG_QUEUE_LIMIT 15'h0011
`define REG_AUTOCLEAR 15'h0012
`define REG_STAT_BYTES 15'h0013
`define REG_INTX_EN_LO 15'h0014
`define REG_INTX_EN_HI 15'h0015
`define REG_INTY_EN_LO 15'h0016
`define REG_INTY_EN_HI 15'h0017
`define REG_GPIO_ROUTE 15'h0018
`define REG_SEQ_STATUS 15'h0019
`define REG_CMP_BASE 15'h0020
`define REG_IO_SUPPLY 15'h00b4
`define IO_SUPPLY_RESET 16'h0001
`define RUN_BIT 0
`define EXT_SYNC_BIT 1
`define QFLAG_BIT 0
`define QACLR_BIT 12
`define CMP_VALUE_LSB 0
`define CMP_SHIFT_LSB 8
`define CMP_KIND_BIT 13
`define CMP_CHAN_BIT 14
`define CMP_DIR_BIT 15
`define WAKE_TIME_NS 1000
`define CLK_PERIOD_NS 10
`define WAKE_CYCLES ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* logic/sensor_exec_and_irq_status.v */
// Purpose: run/standby sequencer and interrupt status for a 12-slot front end
// Assumes: i_ref_clk stands for the low frequency oscillator domain
// Notes: slot data updates and queue count come from the conversion logic
`timescale 1ns/1ps
`include "sensor_exec_regs.vh"
module sensor_exec_and_irq_status #(
  parameter NSLOT = 12,
  parameter SLOT_CYCLES = 16,
  parameter QW = 10
)(
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // register port
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [14:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  // conversion side
  input wire i_ext_sync,
  input wire [NSLOT-1:0] i_slot_enable,
  input wire [NSLOT-1:0] i_slot_update,
  input wire [24*NSLOT-1:0] i_slot_sig,
  input wire [24*NSLOT-1:0] i_slot_dark,
  input wire [NSLOT-1:0] i_ceil_ch_one,
  input wire [NSLOT-1:0] i_ceil_ch_two,
  input wire i_ceiling_detect_en,
  input wire [NSLOT-1:0] i_slot_data_read,
  input wire i_queue_read,
  input wire [QW-1:0] i_queue_count,
  // sequencer outputs
  output wire o_run_active,
  output wire o_seq_reset,
  output reg [3:0] o_slot_index,
  output wire o_slot_busy,
  output reg [7:0] o_status_byte,
  output wire [8:0] o_status_byte_en,
  // interrupts and pins
  output wire o_int_x,
  output wire o_int_y,
  output reg [3:0] o_gpio
);

  // =============================================
  // control registers
  reg run_ff;
  reg external_sync_enable_ff;
  reg [QW-1:0] queue_limit_ff;
  reg [NSLOT-1:0] data_aclr_ff;
  reg queue_aclr_ff;
  reg [8:0] stat_bytes_ff;
  reg [31:0] intx_en_ff;
  reg [31:0] inty_en_ff;
  reg [7:0] gpio_route_ff;
  reg [15:0] io_supply_ff;
  reg [15:0] cmp_cfg_ff [0:2*NSLOT-1];

  wire wr_mode_ok = ~run_ff;
  integer k;

  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      run_ff <= 1'b0;
      external_sync_enable_ff <= 1'b0;
      queue_limit_ff <= {QW{1'b0}};
      data_aclr_ff <= {NSLOT{1'b0}};
      queue_aclr_ff <= 1'b0;
      stat_bytes_ff <= 9'h000;
      intx_en_ff <= 32'h0000_0000;
      inty_en_ff <= 32'h0000_0000;
      gpio_route_ff <= 8'h00;
      io_supply_ff <= `IO_SUPPLY_RESET;
      for (k = 0; k < 2*NSLOT; k = k + 1)
        cmp_cfg_ff[k] <= 16'h0000;
    end
    else if (i_reg_wr)
    begin
      // mode writes only land in standby
      if (i_reg_addr == `REG_RUN_CTRL)
      begin
        run_ff <= i_reg_wdata[`RUN_BIT];
        if (wr_mode_ok)
          external_sync_enable_ff <= i_reg_wdata[`EXT_SYNC_BIT];
      end
      if (wr_mode_ok)
      begin
        case (i_reg_addr)
          `REG_QUEUE_LIMIT: queue_limit_ff <= i_reg_wdata[QW-1:0];
          `REG_AUTOCLEAR:
          begin
            data_aclr_ff <= i_reg_wdata[NSLOT-1:0];
            queue_aclr_ff <= i_reg_wdata[`QACLR_BIT];
          end
          `REG_STAT_BYTES: stat_bytes_ff <= i_reg_wdata[8:0];
          `REG_INTX_EN_LO: intx_en_ff[15:0] <= i_reg_wdata;
          `REG_INTX_EN_HI: intx_en_ff[31:16] <= i_reg_wdata;
          `REG_INTY_EN_LO: inty_en_ff[15:0] <= i_reg_wdata;
          `REG_INTY_EN_HI: inty_en_ff[31:16] <= i_reg_wdata;
          `REG_GPIO_ROUTE: gpio_route_ff <= i_reg_wdata[7:0];
          `REG_IO_SUPPLY: io_supply_ff <= i_reg_wdata;
          default:
          begin
            for (k = 0; k < 2*NSLOT; k = k + 1)
              if (i_reg_addr == `REG_CMP_BASE + k)
                cmp_cfg_ff[k] <= i_reg_wdata;
          end
        endcase
      end
    end
  end

  // =============================================
  // external sync capture
  reg sync_m_ff;
  reg sync_s_ff;
  reg sync_d_ff;
  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      sync_m_ff <= 1'b0;
      sync_s_ff <= 1'b0;
      sync_d_ff <= 1'b0;
    end
    else
    begin
      sync_m_ff <= i_ext_sync;
      sync_s_ff <= sync_m_ff;
      sync_d_ff <= sync_s_ff;
    end
  end
  wire sync_rise = sync_s_ff & ~sync_d_ff;

  // =============================================
  // sequencer
  localparam ST_STANDBY = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_WAKE = 2'h2;
  localparam ST_SLOTS = 2'h3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  reg [3:0] nxt_slot;
  reg [3:0] seq_ff;
  reg pass_done;

  // run writes steer the sequencer at their own edge, so start and stop are not a cycle late
  wire run_wr_hit = i_reg_wr && (i_reg_addr == `REG_RUN_CTRL);
  wire nxt_run = run_wr_hit ? i_reg_wdata[`RUN_BIT] : run_ff;
  wire nxt_ext = (run_wr_hit && wr_mode_ok) ? i_reg_wdata[`EXT_SYNC_BIT] : external_sync_enable_ff;

  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_slot = o_slot_index;
    pass_done = 1'b0;
    case (state_ff)
      ST_STANDBY:
        if (nxt_run)
          nxt_state = nxt_ext ? ST_SLEEP : ST_WAKE;
      ST_SLEEP:
        if (~external_sync_enable_ff || sync_rise)
        begin
          nxt_state = ST_WAKE;
          nxt_cnt = 16'h0000;
        end
      ST_WAKE:
        if (cnt_ff == `WAKE_CYCLES - 1)
        begin
          nxt_state = ST_SLOTS;
          nxt_cnt = 16'h0000;
          nxt_slot = 4'h0;
        end
        else
          nxt_cnt = cnt_ff + 16'h0001;
      ST_SLOTS:
        // syncs seen here are dropped
        if (~i_slot_enable[o_slot_index] || cnt_ff == SLOT_CYCLES - 1)
        begin
          nxt_cnt = 16'h0000;
          if (o_slot_index == NSLOT - 1)
          begin
            pass_done = 1'b1;
            nxt_state = ST_SLEEP;
          end
          else
            nxt_slot = o_slot_index + 4'h1;
        end
        else
          nxt_cnt = cnt_ff + 16'h0001;
      default: nxt_state = ST_STANDBY;
    endcase
    if (~nxt_run)
    begin
      nxt_state = ST_STANDBY;
      nxt_cnt = 16'h0000;
      nxt_slot = 4'h0;
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state_ff <= ST_STANDBY;
      cnt_ff <= 16'h0000;
      o_slot_index <= 4'h0;
      seq_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      o_slot_index <= nxt_slot;
      if (pass_done)
        seq_ff <= seq_ff + 4'h1;
    end
  end

  assign o_run_active = (state_ff != ST_STANDBY);
  assign o_seq_reset = (state_ff == ST_STANDBY);
  assign o_slot_busy = (state_ff == ST_SLOTS) & i_slot_enable[o_slot_index];

  // =============================================
  // status flags, set wins over clear
  reg [NSLOT-1:0] data_flag_ff;
  reg [NSLOT-1:0] level_zero_flag_ff;
  reg [NSLOT-1:0] level_one_flag_ff;
  reg [NSLOT-1:0] ceiling_flag_ch_one_ff;
  reg [NSLOT-1:0] ceiling_flag_ch_two_ff;
  reg queue_fill_flag_ff;
  wire [NSLOT-1:0] lev0_hit;
  wire [NSLOT-1:0] lev1_hit;

  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1)
    begin : g_cmp
      wire [15:0] c0 = cmp_cfg_ff[2*g];
      wire [15:0] c1 = cmp_cfg_ff[2*g+1];
      wire [23:0] sig = i_slot_sig[24*g +: 24];
      wire [23:0] drk = i_slot_dark[24*g +: 24];
      // kind bit XOR channel bit picks the dark or signal lane of the slot
      wire [31:0] d0 = {8'h00, c0[`CMP_KIND_BIT] ^ c0[`CMP_CHAN_BIT] ? drk : sig};
      wire [31:0] d1 = {8'h00, c1[`CMP_KIND_BIT] ^ c1[`CMP_CHAN_BIT] ? drk : sig};
      // shift field clamps at 24
      wire [4:0] s0 = (c0[12:8] > 5'd24) ? 5'd24 : c0[12:8];
      wire [4:0] s1 = (c1[12:8] > 5'd24) ? 5'd24 : c1[12:8];
      wire [31:0] t0 = {24'h000000, c0[7:0]} << s0;
      wire [31:0] t1 = {24'h000000, c1[7:0]} << s1;
      assign lev0_hit[g] = i_slot_update[g] & (c0[`CMP_DIR_BIT] ? d0 > t0 : d0 < t0);
      assign lev1_hit[g] = i_slot_update[g] & (c1[`CMP_DIR_BIT] ? d1 > t1 : d1 < t1);
    end
  endgenerate

  wire wr_c = i_reg_wr;
  wire [NSLOT-1:0] wd = i_reg_wdata[NSLOT-1:0];
  wire [NSLOT-1:0] wclr_data = (wr_c && i_reg_addr == `REG_DATA_FLAGS) ? wd : {NSLOT{1'b0}};
  wire [NSLOT-1:0] wclr_l0 = (wr_c && i_reg_addr == `REG_LEVEL_FLAGS0) ? wd : {NSLOT{1'b0}};
  wire [NSLOT-1:0] wclr_l1 = (wr_c && i_reg_addr == `REG_LEVEL_FLAGS1) ? wd : {NSLOT{1'b0}};
  wire [NSLOT-1:0] wclr_c1 = (wr_c && i_reg_addr == `REG_CEIL_CH1) ? wd : {NSLOT{1'b0}};
  wire [NSLOT-1:0] wclr_c2 = (wr_c && i_reg_addr == `REG_CEIL_CH2) ? wd : {NSLOT{1'b0}};
  wire wclr_q = wr_c && i_reg_addr == `REG_QUEUE_FLAG && i_reg_wdata[`QFLAG_BIT];
  wire [NSLOT-1:0] aclr_data = data_aclr_ff & i_slot_data_read;
  wire q_above = i_queue_count > queue_limit_ff;
  wire q_below = i_queue_count < queue_limit_ff;

  always @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      data_flag_ff <= {NSLOT{1'b0}};
      level_zero_flag_ff <= {NSLOT{1'b0}};
      level_one_flag_ff <= {NSLOT{1'b0}};
      ceiling_flag_ch_one_ff <= {NSLOT{1'b0}};
      ceiling_flag_ch_two_ff <= {NSLOT{1'b0}};
      queue_fill_flag_ff <= 1'b0;
    end
    else
    begin
      data_flag_ff <= (data_flag_ff & ~(wclr_data | aclr_data)) | i_slot_update;
      level_zero_flag_ff <= (level_zero_flag_ff & ~wclr_l0) | lev0_hit;
      level_one_flag_ff <= (level_one_flag_ff & ~wclr_l1) | lev1_hit;
      ceiling_flag_ch_one_ff <= (ceiling_flag_ch_one_ff & ~wclr_c1)
        | (i_ceil_ch_one & {NSLOT{i_ceiling_detect_en}});
      ceiling_flag_ch_two_ff <= (ceiling_flag_ch_two_ff & ~wclr_c2)
        | (i_ceil_ch_two & {NSLOT{i_ceiling_detect_en}});
      if (q_above)
        queue_fill_flag_ff <= 1'b1;
      else if (wclr_q || (q_below && i_queue_read) || (queue_aclr_ff && i_queue_read))
        queue_fill_flag_ff <= 1'b0;
    end
  end

  // =============================================
  // interrupt outputs and pins
  wire [31:0] all_flags = {7'h00, queue_fill_flag_ff, level_one_flag_ff, level_zero_flag_ff};
  assign o_int_x = |(all_flags & intx_en_ff);
  assign o_int_y = |(all_flags & inty_en_ff);

  integer p;
  always @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_gpio <= 4'h0;
    else
      for (p = 0; p < 4; p = p + 1)
        case (gpio_route_ff[2*p +: 2])
          2'h1: o_gpio[p] <= o_int_x;
          2'h2: o_gpio[p] <= o_int_y;
          2'h3: o_gpio[p] <= seq_ff[p];
          default: o_gpio[p] <= 1'b0;
        endcase
  end

  // =============================================
  // status byte and register reads
  assign o_status_byte_en = stat_bytes_ff;
  integer r;

  always @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_status_byte <= 8'h00;
    else
      o_status_byte <= {2'b00, |level_one_flag_ff, |level_zero_flag_ff, seq_ff};
  end

  always @*
  begin
    o_reg_rdata = 16'h0000;
    case (i_reg_addr)
      `REG_DATA_FLAGS: o_reg_rdata[NSLOT-1:0] = data_flag_ff;
      `REG_LEVEL_FLAGS0: o_reg_rdata[NSLOT-1:0] = level_zero_flag_ff;
      `REG_LEVEL_FLAGS1: o_reg_rdata[NSLOT-1:0] = level_one_flag_ff;
      `REG_CEIL_CH1: o_reg_rdata[NSLOT-1:0] = ceiling_flag_ch_one_ff;
      `REG_CEIL_CH2: o_reg_rdata[NSLOT-1:0] = ceiling_flag_ch_two_ff;
      `REG_QUEUE_FLAG: o_reg_rdata[0] = queue_fill_flag_ff;
      `REG_RUN_CTRL: o_reg_rdata[1:0] = {external_sync_enable_ff, run_ff};
      `REG_QUEUE_LIMIT: o_reg_rdata[QW-1:0] = queue_limit_ff;
      `REG_AUTOCLEAR: o_reg_rdata = {3'h0, queue_aclr_ff, data_aclr_ff};
      `REG_STAT_BYTES: o_reg_rdata[8:0] = stat_bytes_ff;
      `REG_INTX_EN_LO: o_reg_rdata = intx_en_ff[15:0];
      `REG_INTX_EN_HI: o_reg_rdata = intx_en_ff[31:16];
      `REG_INTY_EN_LO: o_reg_rdata = inty_en_ff[15:0];
      `REG_INTY_EN_HI: o_reg_rdata = inty_en_ff[31:16];
      `REG_GPIO_ROUTE: o_reg_rdata[7:0] = gpio_route_ff;
      `REG_SEQ_STATUS: o_reg_rdata = {8'h00, o_slot_index, 2'b00, state_ff} | {seq_ff, 12'h000};
      `REG_IO_SUPPLY: o_reg_rdata = io_supply_ff;
      default:
      begin
        for (r = 0; r < 2*NSLOT; r = r + 1)
          if (i_reg_addr == `REG_CMP_BASE + r)
            o_reg_rdata = cmp_cfg_ff[r];
      end
    endcase
  end

endmodule // sensor_exec_and_irq_status

/* sim/sensor_exec_monitor.sv */
// Purpose: port checker for the run sequencer and status flags
// Assumes: one clock domain, i_srst synchronous active high
// Notes: flags are watched through the combinational read port
`timescale 1ns/1ps
`include "sensor_exec_regs.vh"
module sensor_exec_monitor #(
  parameter NSLOT = 12
)(
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  // register port
  input wire i_reg_wr,
  input wire [14:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire [15:0] o_reg_rdata,
  // events
  input wire [NSLOT-1:0] i_slot_update,
  input wire [NSLOT-1:0] i_ceil_ch_one,
  input wire i_ceiling_detect_en,
  // sequencer
  input wire o_run_active,
  input wire o_seq_reset,
  input wire o_slot_busy,
  input wire [7:0] o_status_byte
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  wire run_wr = i_reg_wr && (i_reg_addr == `REG_RUN_CTRL);
  // ==========================================================
  // run control
  a_reset_standby: assert property (
    disable iff (1'b0) i_srst |=> !o_run_active && o_seq_reset)
    else $error("not in standby after reset");
  a_standby_mirror: assert property (
    o_seq_reset |-> !o_run_active && !o_slot_busy
      && (i_reg_addr != `REG_SEQ_STATUS || o_reg_rdata[7:0] == 8'h00))
    else $error("standby leaves sequencer state");
  a_stop_at_once: assert property (
    run_wr && !i_reg_wdata[0] |=> !o_run_active)
    else $error("run not stopped");
  a_start_at_once: assert property (
    run_wr && i_reg_wdata[1:0] == 2'b01 && !o_run_active |=> o_run_active)
    else $error("run not started");
  a_sync_sleeps: assert property (
    run_wr && i_reg_wdata[1:0] == 2'b11 && !o_run_active |=> !o_slot_busy [*8])
    else $error("slot ran before sync");
  a_seq_steps: assert property (
    o_run_active && $changed(o_status_byte[3:0])
    |-> o_status_byte[3:0] == $past(o_status_byte[3:0]) + 4'h1)
    else $error("sequence count skipped");
  // ==========================================================
  // status flags, mode lock and covers
  a_update_sets: assert property (
    i_slot_update != 0 ##1 i_reg_addr == `REG_DATA_FLAGS
    |-> (o_reg_rdata[NSLOT-1:0] & $past(i_slot_update)) == $past(i_slot_update))
    else $error("data flag not set");
  a_ceiling_latch: assert property (
    i_ceiling_detect_en && i_ceil_ch_one != 0 ##1 i_reg_addr == `REG_CEIL_CH1
    |-> (o_reg_rdata[NSLOT-1:0] & $past(i_ceil_ch_one)) == $past(i_ceil_ch_one))
    else $error("ceiling flag not latched");
  a_w1c_clears: assert property (
    i_reg_wr && i_reg_addr == `REG_DATA_FLAGS && i_slot_update == 0
    ##1 i_reg_addr == `REG_DATA_FLAGS |-> (o_reg_rdata & $past(i_reg_wdata)) == 16'h0000)
    else $error("flag not cleared by one");
  a_mode_locked: assert property (
    i_reg_wr && o_run_active && i_reg_addr == `REG_QUEUE_LIMIT
    ##1 i_reg_addr == `REG_QUEUE_LIMIT |-> o_reg_rdata == $past(o_reg_rdata))
    else $error("mode write taken while running");
  c_run_start: cover property (run_wr ##1 o_run_active);
  c_slot_busy: cover property ($rose(o_slot_busy));
  c_seq_wrap: cover property (o_status_byte[3:0] == 4'hf ##[1:400] o_status_byte[3:0] == 4'h0);
endmodule // sensor_exec_monitor

bind sensor_exec_and_irq_status sensor_exec_monitor #(.NSLOT(NSLOT)) i_monitor (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_slot_update(i_slot_update),
  .i_ceil_ch_one(i_ceil_ch_one), .i_ceiling_detect_en(i_ceiling_detect_en),
  .o_run_active(o_run_active), .o_seq_reset(o_seq_reset), .o_slot_busy(o_slot_busy),
  .o_status_byte(o_status_byte)
);

/* sim/host_model.sv */
// Purpose: host processor model on the register port
// Assumes: requests launched and released at the falling edge
// Notes: reads are combinational, data taken at the rising edge
`timescale 1ns/1ps
`include "sensor_exec_regs.vh"
module host_model (
  // clock
  input wire i_ref_clk,
  // register port
  output logic o_wr,
  output logic o_rd,
  output logic [14:0] o_addr,
  output logic [15:0] o_wdata,
  input wire [15:0] i_rdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 15'h0000;
    o_wdata = 16'h0000;
  end
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_ref_clk);
    o_wr = 1'b0;
    // released data must not look valid
    o_wdata = ~d;
    // one idle edge so a following call never re-raises the strobe in this step
    @(negedge i_ref_clk);
  endtask
  task automatic rd(input logic [14:0] a, output logic [15:0] d);
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_ref_clk);
    d = i_rdata;
    @(negedge i_ref_clk);
    o_rd = 1'b0;
    @(negedge i_ref_clk);
  endtask
  // mode registers only change from standby
  task automatic cfg(input logic [14:0] a, input logic [15:0] d);
    wr(`REG_RUN_CTRL, 16'h0000);
    wr(a, d);
  endtask
endmodule // host_model

/* sim/test_sensor_exec_and_irq_status.sv */
// Purpose: self-checking bench for the run sequencer and status flags
// Assumes: SLOT_CYCLES of 4 keeps each pass short
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`include "sensor_exec_regs.vh"
module test_sensor_exec_and_irq_status;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr, rd, run_active, seq_reset, slot_busy, int_x, int_y;
  logic sync = 1'b0, ceil_en = 1'b0, q_read = 1'b0;
  logic [14:0] addr;
  logic [15:0] wdata, rdata, rv;
  logic [11:0] upd = 0, slot_en = 12'hfff, c_one = 0, c_two = 0, d_read = 0;
  logic [287:0] sig = 0;
  logic [9:0] q_count = 0;
  logic [3:0] slot_index, gpio;
  logic [7:0] status_byte;
  logic [8:0] status_en;
  int n_errors = 0, samples_checked = 0, n;
  always #5 clk = ~clk;
  sensor_exec_and_irq_status #(.SLOT_CYCLES(4)) i_dut (
    .i_ref_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_ext_sync(sync), .i_slot_enable(slot_en),
    .i_slot_update(upd), .i_slot_sig(sig), .i_slot_dark(288'h0), .i_ceil_ch_one(c_one),
    .i_ceil_ch_two(c_two), .i_ceiling_detect_en(ceil_en), .i_slot_data_read(d_read),
    .i_queue_read(q_read), .i_queue_count(q_count), .o_run_active(run_active),
    .o_seq_reset(seq_reset), .o_slot_index(slot_index), .o_slot_busy(slot_busy),
    .o_status_byte(status_byte), .o_status_byte_en(status_en), .o_int_x(int_x),
    .o_int_y(int_y), .o_gpio(gpio));
  host_model i_host (.i_ref_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic rdchk(input logic [14:0] a, input logic [15:0] exp);
    i_host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic pulse(input logic [11:0] m);
    upd = m;
    tick(1);
    upd = 12'h000;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk({run_active, seq_reset, int_x, int_y, gpio}, 8'h40);
    rdchk(`REG_RUN_CTRL, 16'h0000);
    rdchk(`REG_IO_SUPPLY, `IO_SUPPLY_RESET);
    rdchk(15'h7fff, 16'h0000);
    rdchk(`REG_SEQ_STATUS, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_run;
    int k;
    i_host.wr(`REG_QUEUE_LIMIT, 16'h0020);
    i_host.wr(`REG_RUN_CTRL, 16'h0001);
    chk({run_active, seq_reset}, 2'b10);
    n = 0;
    while (slot_busy !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    for (k = 0; k < 12; k++)
    begin
      chk(slot_index, k[3:0]);
      tick(4);
    end
    for (k = 1; k <= 16; k++)
    begin
      n = 0;
      while (status_byte[3:0] !== k[3:0] && n < 400)
      begin
        tick(1);
        n++;
      end
      chk(status_byte, {4'h0, k[3:0]});
    end
    i_host.wr(`REG_QUEUE_LIMIT, 16'h0055);
    rdchk(`REG_QUEUE_LIMIT, 16'h0020);
    i_host.wr(`REG_RUN_CTRL, 16'h0000);
    chk({run_active, seq_reset}, 2'b01);
    $display("test run done");
  endtask
  task automatic t_sync;
    int b;
    i_host.wr(`REG_RUN_CTRL, 16'h0003);
    tick(30);
    chk(slot_busy, 0);
    sync = 1'b1;
    n = 0;
    while (slot_busy !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    chk(n >= 100 && n < 110, 1);
    sync = 1'b0;
    tick(3);
    // second edge lands inside the pass
    sync = 1'b1;
    b = 0;
    repeat (400)
    begin
      tick(1);
      b += (slot_busy === 1'b1);
    end
    chk(b < 48, 1);
    sync = 1'b0;
    i_host.wr(`REG_RUN_CTRL, 16'h0000);
    // one pass ran under sync: standby, slot 0, sequence 1
    rdchk(`REG_SEQ_STATUS, 16'h1000);
    $display("test sync done");
  endtask
  task automatic t_flags;
    pulse(12'h801);
    rdchk(`REG_DATA_FLAGS, 16'h0801);
    i_host.wr(`REG_DATA_FLAGS, 16'h0001);
    rdchk(`REG_DATA_FLAGS, 16'h0800);
    upd = 12'h800;
    i_host.wr(`REG_DATA_FLAGS, 16'h0800);
    upd = 12'h000;
    rdchk(`REG_DATA_FLAGS, 16'h0800);
    i_host.cfg(`REG_DATA_FLAGS, 16'h0800);
    i_host.cfg(`REG_AUTOCLEAR, 16'h0002);
    pulse(12'h002);
    d_read = 12'h001;
    tick(1);
    rdchk(`REG_DATA_FLAGS, 16'h0002);
    d_read = 12'h002;
    tick(1);
    d_read = 12'h000;
    rdchk(`REG_DATA_FLAGS, 16'h0000);
    i_host.cfg(`REG_CMP_BASE, 16'h8412);
    i_host.cfg(`REG_CMP_BASE + 15'h0001, 16'h0001);
    sig[23:0] = 24'h000120;
    pulse(12'h001);
    rdchk(`REG_LEVEL_FLAGS0, 16'h0000);
    sig[23:0] = 24'h000121;
    pulse(12'h001);
    rdchk(`REG_LEVEL_FLAGS0, 16'h0001);
    rdchk(`REG_LEVEL_FLAGS1, 16'h0000);
    sig[23:0] = 24'h000000;
    pulse(12'h001);
    rdchk(`REG_LEVEL_FLAGS1, 16'h0001);
    chk(status_byte[5:4], 2'b11);
    i_host.cfg(`REG_INTX_EN_LO, 16'h0001);
    chk({int_x, int_y}, 2'b10);
    i_host.cfg(`REG_INTY_EN_HI, 16'h0100);
    i_host.cfg(`REG_QUEUE_LIMIT, 16'h0010);
    chk(int_y, 0);
    q_count = 10'd17;
    tick(1);
    rdchk(`REG_QUEUE_FLAG, 16'h0001);
    i_host.cfg(`REG_GPIO_ROUTE, 16'h0009);
    tick(1);
    chk(gpio, 4'h3);
    q_count = 10'd16;
    q_read = 1'b1;
    tick(1);
    rdchk(`REG_QUEUE_FLAG, 16'h0001);
    q_count = 10'd15;
    tick(1);
    q_read = 1'b0;
    rdchk(`REG_QUEUE_FLAG, 16'h0000);
    chk(int_y, 0);
    q_count = 10'd17;
    i_host.cfg(`REG_AUTOCLEAR, 16'h1000);
    q_count = 10'd16;
    rdchk(`REG_QUEUE_FLAG, 16'h0001);
    i_host.wr(`REG_QUEUE_FLAG, 16'h0001);
    rdchk(`REG_QUEUE_FLAG, 16'h0000);
    q_count = 10'd17;
    tick(1);
    q_count = 10'd16;
    rdchk(`REG_QUEUE_FLAG, 16'h0001);
    q_read = 1'b1;
    tick(1);
    q_read = 1'b0;
    rdchk(`REG_QUEUE_FLAG, 16'h0000);
    i_host.cfg(`REG_INTX_EN_LO, 16'h0000);
    chk(int_x, 0);
    rdchk(`REG_LEVEL_FLAGS0, 16'h0001);
    c_one = 12'h004;
    tick(1);
    c_one = 12'h000;
    ceil_en = 1'b1;
    c_two = 12'h008;
    tick(1);
    c_one = 12'h000;
    c_two = 12'h000;
    rdchk(`REG_CEIL_CH1, 16'h0000);
    rdchk(`REG_CEIL_CH2, 16'h0008);
    c_one = 12'h004;
    tick(1);
    c_one = 12'h000;
    rdchk(`REG_CEIL_CH1, 16'h0004);
    i_host.wr(`REG_CEIL_CH1, 16'h0004);
    rdchk(`REG_CEIL_CH1, 16'h0000);
    i_host.cfg(`REG_STAT_BYTES, 16'h01ff);
    tick(1);
    chk(status_en, 9'h1ff);
    i_host.cfg(`REG_GPIO_ROUTE, 16'h00ff);
    tick(1);
    chk(gpio, 4'h1);
    chk(status_byte, 8'h31);
    $display("test flags done");
  endtask
  initial
  begin
    #200000;
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish;
  end
  initial
  begin
    tick(6);
    srst = 1'b0;
    tick(1);
    t_reset;
    t_run;
    t_sync;
    t_flags;
    tally_and_finish;
  end
endmodule // test_sensor_exec_and_irq_status
